// file: dmapg_pkg.sv
// Constants and types shared by the DMA page address generator.
// Assumes a byte-wide I/O port bus and a single system clock domain.
package dmapg_pkg;

    // ****************************************************************
    // Page register port addresses
    // ****************************************************************
    localparam logic [15:0] DMAPG_PORT_CH0 = 16'h0087;
    localparam logic [15:0] DMAPG_PORT_CH1 = 16'h0083;
    localparam logic [15:0] DMAPG_PORT_CH2 = 16'h0081;
    localparam logic [15:0] DMAPG_PORT_CH3 = 16'h0082;
    localparam logic [15:0] DMAPG_PORT_CH5 = 16'h008b;
    localparam logic [15:0] DMAPG_PORT_CH6 = 16'h0089;
    localparam logic [15:0] DMAPG_PORT_CH7 = 16'h008a;
    localparam logic [15:0] DMAPG_PORT_REFRESH = 16'h008f;

    // ****************************************************************
    // Storage layout and reset values
    // ****************************************************************
    localparam int DMAPG_NUM_SLOTS = 8;
    localparam int DMAPG_CTRL_CH = 4;
    localparam logic [2:0] DMAPG_IDX_REFRESH = 3'h4;
    localparam logic [2:0] DMAPG_IDX_WIDE_BASE = 3'h5;
    localparam logic [7:0] DMAPG_PAGE_RST = 8'h00;
    localparam logic [7:0] DMAPG_RDATA_RST = 8'h00;
    localparam logic [23:0] DMAPG_ADDR_RST = 24'h000000;

    // ****************************************************************
    // Cycle classes
    // ****************************************************************
    typedef enum logic [3:0] {
        DMAPG_CYC_IDLE = 4'h1,
        DMAPG_CYC_NARROW = 4'h2,
        DMAPG_CYC_WIDE = 4'h4,
        DMAPG_CYC_REFRESH = 4'h8
    } dmapg_cyc_e;

endpackage : dmapg_pkg

// file: dmapg_addr_form.sv
// Combinational former of a 24-bit system address and byte-high select.
// Assumes the caller registers the results before they leave the chip.
`timescale 1ns/1ps
module dmapg_addr_form (
    input wire logic [7:0] page_i,
    input wire logic [15:0] offset_i,
    input wire logic wide_i,
    output logic [23:0] addr_o,
    output logic byte_high_select_o
);

    // ****************************************************************
    // Address forming
    // ****************************************************************
    always_comb
    begin
        if (wide_i)
        begin
            // The low page bit is dropped since the shifted offset owns A16.
            addr_o = {page_i[7:1], offset_i, 1'b0};
            byte_high_select_o = 1'b0;
        end
        else
        begin
            addr_o = {page_i, offset_i};
            byte_high_select_o = ~offset_i[0];
        end
    end

endmodule : dmapg_addr_form

// file: dmapg_top.sv
// Page registers and system address generation for two cascaded DMA controllers.
// Assumes the controllers, refresh logic and I/O decoder share ref_clk_i.
//
// Summary of operation
// - Eight channels come from two four-channel controllers, 0-3 on the first and 4-7 on the second.
// - Channel 4 of the second controller only cascades the first controller and never transfers itself.
// - Channels 0 to 3 move 8-bit data between 8-bit adapters and 8- or 16-bit memory.
// - An 8-bit channel moves blocks of up to 64KB placed anywhere in the 16MB space.
// - Channels 5 to 7 move 16-bit data between 16-bit adapters and 16-bit memory.
// - A 16-bit channel moves blocks of up to 128KB placed anywhere in the 16MB space.
// - The 16-bit channels only ever present even byte addresses.
// - Page registers sit at ports 87, 83, 81, 82, 8B, 89, 8A and refresh at 8F.
// - For channels 0 to 3 the page drives A23-A16 and the controller drives A15-A0.
// - For channels 5 to 7 the page drives A23-A17 and the shifted controller output drives A16-A1.
// - On 8-bit cycles the byte-high select is the inverse of A0.
// - On 16-bit cycles both the byte-high select and A0 are zero.
// - Address counting never carries into or borrows from the page, so it wraps in its page.
`timescale 1ns/1ps
module dmapg_top #(
    parameter int PAGE_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_ack_o,
    input wire logic [3:0] ctrl1_dack_i,
    input wire logic [15:0] ctrl1_addr_i,
    input wire logic [3:0] ctrl2_dack_i,
    input wire logic [15:0] ctrl2_addr_i,
    input wire logic refresh_i,
    input wire logic [15:0] refresh_addr_i,
    output logic [23:0] sys_addr_o,
    output logic byte_high_select_o,
    output logic dma_cycle_o,
    output logic wide_cycle_o,
    output logic refresh_cycle_o,
    output logic [2:0] chan_o,
    output logic cascade_err_o
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (PAGE_W != 8)
    begin : g_bad_width
        $error("dmapg_top: PAGE_W must be 8");
    end

    // ****************************************************************
    // Port decode
    // ****************************************************************
    logic [PAGE_W-1:0] page_r [0:dmapg_pkg::DMAPG_NUM_SLOTS-1];
    logic [2:0] io_idx;
    logic io_hit;
    logic wr_hit;
    logic rd_hit;
    logic [7:0] rd_val;

    always_comb
    begin
        io_hit = 1'b1;
        io_idx = 3'h0;
        case (io_addr_i)
            dmapg_pkg::DMAPG_PORT_CH0: io_idx = 3'h0;
            dmapg_pkg::DMAPG_PORT_CH1: io_idx = 3'h1;
            dmapg_pkg::DMAPG_PORT_CH2: io_idx = 3'h2;
            dmapg_pkg::DMAPG_PORT_CH3: io_idx = 3'h3;
            dmapg_pkg::DMAPG_PORT_REFRESH: io_idx = dmapg_pkg::DMAPG_IDX_REFRESH;
            dmapg_pkg::DMAPG_PORT_CH5: io_idx = 3'h5;
            dmapg_pkg::DMAPG_PORT_CH6: io_idx = 3'h6;
            dmapg_pkg::DMAPG_PORT_CH7: io_idx = 3'h7;
            default: io_hit = 1'b0;
        endcase
    end

    assign wr_hit = io_wr_i & io_hit;
    assign rd_hit = io_rd_i & io_hit;
    assign rd_val = page_r[io_idx];

    // ****************************************************************
    // Page register bank
    // ****************************************************************
    // Slot 4 holds the refresh page, since channel 4 never needs a page of its own.
    for (genvar g = 0; g < dmapg_pkg::DMAPG_NUM_SLOTS; g++)
    begin : g_page
        always_ff @(posedge ref_clk_i)
        begin
            if (rst_i)
            begin
                page_r[g] <= dmapg_pkg::DMAPG_PAGE_RST;
            end
            else if (wr_hit && (io_idx == 3'(g)))
            begin
                page_r[g] <= io_wdata_i;
            end
        end
    end

    // ****************************************************************
    // Read back
    // ****************************************************************
    // Unmapped reads give no acknowledge, so another device may answer.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            io_rdata_o <= dmapg_pkg::DMAPG_RDATA_RST;
            io_ack_o <= 1'b0;
        end
        else
        begin
            io_ack_o <= rd_hit;
            io_rdata_o <= rd_hit ? rd_val : dmapg_pkg::DMAPG_RDATA_RST;
        end
    end

    // ****************************************************************
    // Channel selection
    // ****************************************************************
    dmapg_pkg::dmapg_cyc_e cyc_nxt;
    dmapg_pkg::dmapg_cyc_e cyc_r;
    logic [2:0] sel_idx;
    logic [15:0] sel_ofs;
    logic [7:0] sel_page;
    logic cascade_nxt;
    logic [23:0] addr_nxt;
    logic bhs_nxt;

    // Lowest acknowledge wins if a controller ever shows more than one.
    always_comb
    begin
        cyc_nxt = dmapg_pkg::DMAPG_CYC_IDLE;
        sel_idx = 3'h0;
        sel_ofs = 16'h0000;
        cascade_nxt = 1'b0;
        if (refresh_i)
        begin
            cyc_nxt = dmapg_pkg::DMAPG_CYC_REFRESH;
            sel_idx = dmapg_pkg::DMAPG_IDX_REFRESH;
            sel_ofs = refresh_addr_i;
        end
        else if (ctrl2_dack_i[0])
        begin
            if (|ctrl1_dack_i)
            begin
                cyc_nxt = dmapg_pkg::DMAPG_CYC_NARROW;
                sel_ofs = ctrl1_addr_i;
                for (int k = dmapg_pkg::DMAPG_CTRL_CH - 1; k >= 0; k--)
                begin
                    if (ctrl1_dack_i[k])
                    begin
                        sel_idx = 3'(k);
                    end
                end
            end
            else
            begin
                cascade_nxt = 1'b1;
            end
        end
        else if (|ctrl2_dack_i[3:1])
        begin
            cyc_nxt = dmapg_pkg::DMAPG_CYC_WIDE;
            sel_ofs = ctrl2_addr_i;
            for (int k = dmapg_pkg::DMAPG_CTRL_CH - 1; k >= 1; k--)
            begin
                if (ctrl2_dack_i[k])
                begin
                    sel_idx = 3'(k + 4);
                end
            end
        end
        else if (|ctrl1_dack_i)
        begin
            // A first-controller grant without the cascade grant is a protocol fault.
            cascade_nxt = 1'b1;
        end
    end

    assign sel_page = page_r[sel_idx];

    // The offset is used as given and never added to the page, so no carry can reach it.
    dmapg_addr_form u_form (
        .page_i(sel_page),
        .offset_i(sel_ofs),
        .wide_i(cyc_nxt == dmapg_pkg::DMAPG_CYC_WIDE),
        .addr_o(addr_nxt),
        .byte_high_select_o(bhs_nxt)
    );

    // ****************************************************************
    // Cycle class register
    // ****************************************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            cyc_r <= dmapg_pkg::DMAPG_CYC_IDLE;
        end
        else
        begin
            cyc_r <= cyc_nxt;
        end
    end

    // ****************************************************************
    // Bus outputs
    // ****************************************************************
    // One cycle of latency; a page written in the same cycle applies from the next.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            sys_addr_o <= dmapg_pkg::DMAPG_ADDR_RST;
            byte_high_select_o <= 1'b0;
            chan_o <= 3'h0;
            cascade_err_o <= 1'b0;
        end
        else
        begin
            case (cyc_nxt)
                dmapg_pkg::DMAPG_CYC_IDLE:
                begin
                    sys_addr_o <= dmapg_pkg::DMAPG_ADDR_RST;
                    byte_high_select_o <= 1'b0;
                end
                default:
                begin
                    sys_addr_o <= addr_nxt;
                    byte_high_select_o <= bhs_nxt;
                end
            endcase
            chan_o <= sel_idx;
            cascade_err_o <= cascade_nxt;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            dma_cycle_o <= 1'b0;
            wide_cycle_o <= 1'b0;
            refresh_cycle_o <= 1'b0;
        end
        else
        begin
            dma_cycle_o <= (cyc_nxt == dmapg_pkg::DMAPG_CYC_NARROW) || (cyc_nxt == dmapg_pkg::DMAPG_CYC_WIDE);
            wide_cycle_o <= (cyc_nxt == dmapg_pkg::DMAPG_CYC_WIDE);
            refresh_cycle_o <= (cyc_nxt == dmapg_pkg::DMAPG_CYC_REFRESH);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_narrow_addr;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cyc_nxt == dmapg_pkg::DMAPG_CYC_NARROW) |=>
            (sys_addr_o == {$past(sel_page), $past(ctrl1_addr_i)}) && dma_cycle_o && !wide_cycle_o;
    endproperty
    a_narrow_addr: assert property (p_narrow_addr) else $error("narrow address wrong");

    property p_narrow_bhs;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cyc_r == dmapg_pkg::DMAPG_CYC_NARROW) |-> (byte_high_select_o == !sys_addr_o[0]);
    endproperty
    a_narrow_bhs: assert property (p_narrow_bhs) else $error("byte high select not inverse of A0");

    property p_wide_zero;
        @(posedge ref_clk_i) disable iff (rst_i)
        wide_cycle_o |-> !byte_high_select_o && !sys_addr_o[0];
    endproperty
    a_wide_zero: assert property (p_wide_zero) else $error("wide cycle odd or byte high set");

    property p_wide_addr;
        @(posedge ref_clk_i) disable iff (rst_i)
        (cyc_nxt == dmapg_pkg::DMAPG_CYC_WIDE) |=>
            (sys_addr_o[16:1] == $past(ctrl2_addr_i)) && (sys_addr_o[23:17] == $past(sel_page[7:1]));
    endproperty
    a_wide_addr: assert property (p_wide_addr) else $error("wide address wrong");

    property p_page_write;
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_hit |=> (page_r[$past(io_idx)] == $past(io_wdata_i));
    endproperty
    a_page_write: assert property (p_page_write) else $error("page write lost");

    property p_readback;
        @(posedge ref_clk_i) disable iff (rst_i)
        rd_hit |=> io_ack_o && (io_rdata_o == $past(rd_val)) ##1 !io_ack_o || $past(rd_hit);
    endproperty
    a_readback: assert property (p_readback) else $error("read back wrong");

    property p_unmapped;
        @(posedge ref_clk_i) disable iff (rst_i)
        !rd_hit |=> !io_ack_o && (io_rdata_o == 8'h00);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped port answered");

    property p_cascade;
        @(posedge ref_clk_i) disable iff (rst_i)
        (!refresh_i && ctrl2_dack_i[0] && !(|ctrl1_dack_i)) |=> cascade_err_o && !dma_cycle_o;
    endproperty
    a_cascade: assert property (p_cascade) else $error("channel 4 transferred");

    property p_orphan;
        @(posedge ref_clk_i) disable iff (rst_i)
        (!refresh_i && !ctrl2_dack_i[0] && (|ctrl1_dack_i)) |=> cascade_err_o && !dma_cycle_o;
    endproperty
    a_orphan: assert property (p_orphan) else $error("first controller moved without cascade grant");

    property p_no_carry;
        @(posedge ref_clk_i) disable iff (rst_i)
        (wide_cycle_o && $past(wide_cycle_o) && (chan_o == $past(chan_o)) && !$past(wr_hit, 2))
            |-> (sys_addr_o[23:17] == $past(sys_addr_o[23:17]));
    endproperty
    a_no_carry: assert property (p_no_carry) else $error("page changed by counting");

    property p_cov_narrow;
        @(posedge ref_clk_i) disable iff (rst_i)
        dma_cycle_o && !wide_cycle_o && sys_addr_o[0];
    endproperty
    c_narrow: cover property (p_cov_narrow);

    property p_cov_wide;
        @(posedge ref_clk_i) disable iff (rst_i)
        wide_cycle_o ##1 wide_cycle_o;
    endproperty
    c_wide: cover property (p_cov_wide);

    property p_cov_refresh;
        @(posedge ref_clk_i) disable iff (rst_i)
        refresh_cycle_o;
    endproperty
    c_refresh: cover property (p_cov_refresh);

    property p_cov_rw;
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_hit ##2 rd_hit ##1 io_ack_o;
    endproperty
    c_rw: cover property (p_cov_rw);

endmodule : dmapg_top

// file: dmapg_ctrl_model.sv
// Behavioural model of the two cascaded DMA controllers and the refresh source.
// Assumes the bench drives its controls at the rising edge of ref_clk_i.
`timescale 1ns/1ps
module dmapg_ctrl_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic run_i,
    input wire logic rfsh_i,
    input wire logic orphan_i,
    input wire logic [2:0] chan_i,
    input wire logic [15:0] base_i,
    output logic [3:0] ctrl1_dack_o,
    output logic [15:0] ctrl1_addr_o,
    output logic [3:0] ctrl2_dack_o,
    output logic [15:0] ctrl2_addr_o,
    output logic refresh_o,
    output logic [15:0] refresh_addr_o
);
    // ********
    // Address counter
    // ********
    logic [15:0] addr_r;
    logic [15:0] last_r;
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            addr_r <= 16'h0000;
            last_r <= 16'h0000;
        end
        else if (load_i)
            addr_r <= base_i;
        else if (run_i)
        begin
            addr_r <= addr_r + 16'h0001;
            last_r <= addr_r;
        end
    end
    // ********
    // Grants and address lines
    // ********
    // Released lines show the inverse of the last address so stale values never pass.
    always_comb
    begin
        ctrl1_dack_o = 4'h0;
        ctrl2_dack_o = 4'h0;
        ctrl1_addr_o = ~last_r;
        ctrl2_addr_o = ~last_r;
        if (run_i && chan_i < 3'h4)
        begin
            ctrl1_dack_o[chan_i[1:0]] = 1'b1;
            // An orphan grant leaves out the cascade acknowledge to reach the fault path.
            ctrl2_dack_o[0] = !orphan_i;
            ctrl1_addr_o = addr_r;
        end
        else if (run_i)
        begin
            ctrl2_dack_o[chan_i[1:0]] = 1'b1;
            ctrl2_addr_o = addr_r;
        end
    end
    assign refresh_o = run_i && rfsh_i;
    assign refresh_addr_o = refresh_o ? addr_r : ~last_r;
endmodule : dmapg_ctrl_model

// file: tb_top.sv
// Self-checking bench for the DMA page address generator.
// Assumes the controller model drives the DMA side of the design.
`timescale 1ns/1ps
module tb_top;
    // ********
    // Signals
    // ********
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] io_addr_i = 16'h0000;
    logic io_wr_i = 1'b0;
    logic io_rd_i = 1'b0;
    logic [7:0] io_wdata_i = 8'h00;
    logic load = 1'b0;
    logic run = 1'b0;
    logic rfsh = 1'b0;
    logic orphan = 1'b0;
    logic [2:0] chan = 3'h0;
    logic [15:0] base = 16'h0000;
    logic [3:0] ctrl1_dack_i, ctrl2_dack_i;
    logic [15:0] ctrl1_addr_i, ctrl2_addr_i, refresh_addr_i;
    logic refresh_i, io_ack_o, byte_high_select_o, dma_cycle_o;
    logic wide_cycle_o, refresh_cycle_o, cascade_err_o;
    logic [7:0] io_rdata_o;
    logic [23:0] sys_addr_o;
    logic [2:0] chan_o;
    logic [15:0] port [0:7];
    logic [7:0] pg [0:7];
    int error_cnt = 0;
    int checked = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    dmapg_top dut_u (.ref_clk_i, .rst_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
        .io_ack_o, .ctrl1_dack_i, .ctrl1_addr_i, .ctrl2_dack_i, .ctrl2_addr_i, .refresh_i,
        .refresh_addr_i, .sys_addr_o, .byte_high_select_o, .dma_cycle_o, .wide_cycle_o,
        .refresh_cycle_o, .chan_o, .cascade_err_o);
    dmapg_ctrl_model model_u (.ref_clk_i, .rst_i, .load_i(load), .run_i(run), .rfsh_i(rfsh),
        .orphan_i(orphan),
        .chan_i(chan), .base_i(base), .ctrl1_dack_o(ctrl1_dack_i), .ctrl1_addr_o(ctrl1_addr_i),
        .ctrl2_dack_o(ctrl2_dack_i), .ctrl2_addr_o(ctrl2_addr_i), .refresh_o(refresh_i),
        .refresh_addr_o(refresh_addr_i));
    // ********
    // Tasks
    // ********
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        io_wr_i <= 1'b1;
        io_addr_i <= a;
        io_wdata_i <= d;
        @(posedge ref_clk_i);
        io_wr_i <= 1'b0;
    endtask : io_wr
    // The answer comes in exactly the cycle after the strobe, so it is sampled there.
    task automatic io_rd(input logic [15:0] a, input logic ok, input logic [7:0] d);
        @(posedge ref_clk_i);
        io_rd_i <= 1'b1;
        io_addr_i <= a;
        @(posedge ref_clk_i);
        io_rd_i <= 1'b0;
        #1;
        chk("io_ack_o", {23'h0, ok}, {23'h0, io_ack_o});
        chk("io_rdata_o", {16'h0, d}, {16'h0, io_rdata_o});
    endtask : io_rd
    task automatic dma(input logic [2:0] ch, input logic r, input logic [15:0] b, input int n);
        logic [15:0] a;
        logic [23:0] e;
        logic wd;
        logic flt;
        wd = ch > 3'h4 && !r;
        // A fault is channel 4 alone or a first-controller grant with no cascade grant.
        flt = !r && (ch == 3'h4 || (orphan && ch < 3'h4));
        @(posedge ref_clk_i);
        load <= 1'b1;
        base <= b;
        chan <= ch;
        rfsh <= r;
        @(posedge ref_clk_i);
        load <= 1'b0;
        run <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk_i);
            #1;
            a = b + 16'(i);
            e = wd ? {pg[ch][7:1], a, 1'b0} : {pg[r ? 3'h4 : ch], a};
            chk("dma_cycle_o", {23'h0, !r && !flt}, {23'h0, dma_cycle_o});
            chk("cascade_err_o", {23'h0, flt}, {23'h0, cascade_err_o});
            if (!flt)
            begin
                chk("sys_addr_o", e, sys_addr_o);
                chk("byte_high_select_o", {23'h0, !wd && !a[0]}, {23'h0, byte_high_select_o});
                chk("chan_o", {21'h0, r ? 3'h4 : ch}, {21'h0, chan_o});
                chk("wide_cycle_o", {23'h0, wd}, {23'h0, wide_cycle_o});
                chk("refresh_cycle_o", {23'h0, r}, {23'h0, refresh_cycle_o});
            end
        end
        @(posedge ref_clk_i);
        run <= 1'b0;
        rfsh <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        chk("sys_addr_o", 24'h0, sys_addr_o);
        chk("dma_cycle_o", 24'h0, {23'h0, dma_cycle_o});
    endtask : dma
    // ********
    // Sequence
    // ********
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        error_cnt++;
        end_sim();
    end
    initial
    begin
        port = '{dmapg_pkg::DMAPG_PORT_CH0, dmapg_pkg::DMAPG_PORT_CH1, dmapg_pkg::DMAPG_PORT_CH2,
            dmapg_pkg::DMAPG_PORT_CH3, dmapg_pkg::DMAPG_PORT_REFRESH, dmapg_pkg::DMAPG_PORT_CH5,
            dmapg_pkg::DMAPG_PORT_CH6, dmapg_pkg::DMAPG_PORT_CH7};
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        chk("sys_addr_o", 24'h0, sys_addr_o);
        for (int k = 0; k < 8; k++)
            io_rd(port[k], 1'b1, 8'h00);
        $display("test reset_values done");
        // Odd pages make the ignored bit 0 of the 16-bit channels visible.
        for (int k = 0; k < 8; k++)
        begin
            pg[k] = 8'h93 + 8'(k * 32);
            io_wr(port[k], pg[k]);
        end
        io_wr(16'h0080, 8'h5a);
        io_wr(16'h0187, 8'h5a);
        io_rd(16'h0187, 1'b0, 8'h00);
        for (int k = 0; k < 8; k++)
            io_rd(port[k], 1'b1, pg[k]);
        $display("test page_ports done");
        for (int k = 0; k < 8; k++)
            dma(3'(k), 1'b0, 16'hfffe, 4);
        pg[1] = 8'h0c;
        io_wr(port[1], pg[1]);
        io_rd(port[1], 1'b1, pg[1]);
        dma(3'h1, 1'b0, 16'h1234, 2);
        // The model is idle here, so switching the orphan grant off the clock edge is harmless.
        orphan = 1'b1;
        dma(3'h3, 1'b0, 16'h0100, 2);
        orphan = 1'b0;
        $display("test channels done");
        dma(3'h2, 1'b1, 16'h7ffe, 3);
        $display("test refresh done");
        end_sim();
    end
endmodule : tb_top
